// >>> rtl/pwm_steer_pkg.sv
package pwm_steer_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] RESTART_DELAY_OFF = 8'h00;
  localparam logic [7:0] STEER_CTRL_OFF = 8'h04;
  localparam logic [7:0] CCP_CTRL_OFF = 8'h08;
  localparam logic [7:0] SHUTDOWN_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h14;

  // Reset values
  localparam logic [7:0] RESTART_DELAY_RST = 8'h00;
  localparam logic [4:0] STEER_CTRL_RST = 5'h01;
  localparam logic [7:0] CCP_CTRL_RST = 8'h00;

  // Field positions and widths
  localparam int AUTO_RESTART_BIT = 7;
  localparam int DELAY_W = 7;
  localparam int STEER_SYNC_BIT = 4;
  localparam int STEER_PINS = 4;
  localparam int CFG_HI = 7;
  localparam int CFG_LO = 6;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int POL_AC_BIT = 1;
  localparam int POL_BD_BIT = 0;
  localparam int SD_FLAG_BIT = 0;
  localparam int SD_COND_BIT = 1;
  localparam int SD_WAIT_BIT = 2;
  localparam int IRQ_SHUTDOWN_BIT = 0;
  localparam int IRQ_RESUME_BIT = 1;
  localparam int IRQ_W = 2;

  // Encodings
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic SHUTDOWN_LEVEL = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One instruction cycle is four oscillator (CLK) periods
  localparam int CLKS_PER_INSTR = 4;
  localparam int DELAY_CNT_W = 9;

endpackage

// >>> rtl/pwm_rise_delay.sv
`timescale 1ns/100ps
module pwm_rise_delay #(
  parameter int CNT_W = pwm_steer_pkg::DELAY_CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw,
  input wire logic [CNT_W-1:0] target,
  output logic out_r
);

  logic [CNT_W-1:0] cnt_r;

  // Rising edge waits target cycles, falling edge passes at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (!raw) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (!out_r) begin
      if (cnt_r >= target) begin
        out_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  a_fall_immediate:
  assert property (@(posedge clk) disable iff (rst) !raw |=> !out_r)
    else $error("falling edge of pwm was delayed");

  a_rise_count:
  assert property (@(posedge clk) disable iff (rst)
    $rose(out_r) |-> $past(raw) && $past(cnt_r) == $past(target))
    else $error("active edge not at programmed delay");

endmodule

// >>> rtl/steer_update_sync.sv
`timescale 1ns/100ps
module steer_update_sync #(
  parameter int PINS = pwm_steer_pkg::STEER_PINS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [PINS-1:0] wr_sel,
  input wire logic wr_sync,
  input wire logic period_start,
  output logic [PINS-1:0] applied_r
);

  logic [PINS-1:0] pend_r;
  logic pend_v_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= pwm_steer_pkg::STEER_CTRL_RST[PINS-1:0];
      pend_v_r <= 1'b0;
    end else if (wr) begin
      pend_r <= wr_sel;
      pend_v_r <= wr_sync;
    end else if (period_start) begin
      pend_v_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      applied_r <= pwm_steer_pkg::STEER_CTRL_RST[PINS-1:0];
    end else if (wr && !wr_sync) begin
      applied_r <= wr_sel;
    end else if (pend_v_r && period_start && !wr) begin
      applied_r <= pend_r;
    end
  end

  a_sync_waits:
  assert property (@(posedge clk) disable iff (rst)
    (wr ? wr_sync : (pend_v_r && !period_start)) |=> $stable(applied_r))
    else $error("synchronised steering applied before period start");

  a_sync_applies:
  assert property (@(posedge clk) disable iff (rst)
    pend_v_r && period_start && !wr |=> applied_r == $past(pend_r))
    else $error("synchronised steering missed period start");

  a_immediate_apply:
  assert property (@(posedge clk) disable iff (rst)
    wr && !wr_sync |=> applied_r == $past(wr_sel))
    else $error("immediate steering not applied after write");

endmodule

// >>> rtl/pwm_steering_restart_delay.sv
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module pwm_steering_restart_delay (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [pwm_steer_pkg::ADDR_W-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [pwm_steer_pkg::DATA_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [pwm_steer_pkg::ADDR_W-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [pwm_steer_pkg::DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic SHUTDOWN_COND,
  input wire logic PERIOD_START,
  input wire logic RAW_PWM,
  input wire logic PORT_OUT_A,
  input wire logic PORT_OUT_B,
  input wire logic PORT_OUT_C,
  input wire logic PORT_OUT_D,
  output logic PWM_OUT_A,
  output logic PWM_OUT_B,
  output logic PWM_OUT_C,
  output logic PWM_OUT_D,
  output logic IRQ
);

  localparam int PINS = pwm_steer_pkg::STEER_PINS;
  localparam int CW = pwm_steer_pkg::DELAY_CNT_W;

  function automatic logic addr_mapped(input logic [pwm_steer_pkg::ADDR_W-1:0] a);
    addr_mapped = (a == pwm_steer_pkg::RESTART_DELAY_OFF) || (a == pwm_steer_pkg::STEER_CTRL_OFF)
      || (a == pwm_steer_pkg::CCP_CTRL_OFF) || (a == pwm_steer_pkg::SHUTDOWN_STAT_OFF)
      || (a == pwm_steer_pkg::IRQ_STATUS_OFF) || (a == pwm_steer_pkg::IRQ_MASK_OFF);
  endfunction

  // Bus slave state
  logic aw_hold_r;
  logic w_hold_r;
  logic [pwm_steer_pkg::ADDR_W-1:0] waddr_r;
  logic [pwm_steer_pkg::DATA_W-1:0] wdata_r;
  logic lane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [pwm_steer_pkg::DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic do_read;
  logic wr_restart;
  logic wr_steer;
  logic wr_ccp;
  logic wr_sd;
  logic wr_irq_clr;
  logic wr_mask;

  // Control and status state
  logic [7:0] restart_delay_r;
  logic [4:0] steer_ctrl_r;
  logic [7:0] ccp_r;
  logic [pwm_steer_pkg::IRQ_W-1:0] irq_status_r;
  logic [pwm_steer_pkg::IRQ_W-1:0] irq_status_nxt;
  logic [pwm_steer_pkg::IRQ_W-1:0] irq_mask_r;
  logic cond_meta_r;
  logic cond_r;
  logic flag_r;
  logic flag_nxt;
  logic resume_wait_r;
  logic shut;
  logic mode_ok;
  logic auto_en;
  logic dly_pwm;
  logic [CW-1:0] dly_target;
  logic [PINS-1:0] steer_app;
  logic [PINS-1:0] port_val;
  logic [PINS-1:0] pol_inv;
  logic [PINS-1:0] pin_r;
  logic [PINS-1:0] pin_nxt;

  assign AWREADY = !aw_hold_r && !bvalid_r;
  assign WREADY = !w_hold_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
  assign do_read = ARVALID && !rvalid_r;

  assign wr_restart = do_write && lane0_r && (waddr_r == pwm_steer_pkg::RESTART_DELAY_OFF);
  assign wr_steer = do_write && lane0_r && (waddr_r == pwm_steer_pkg::STEER_CTRL_OFF);
  assign wr_ccp = do_write && lane0_r && (waddr_r == pwm_steer_pkg::CCP_CTRL_OFF);
  assign wr_sd = do_write && lane0_r && (waddr_r == pwm_steer_pkg::SHUTDOWN_STAT_OFF);
  assign wr_irq_clr = do_write && lane0_r && (waddr_r == pwm_steer_pkg::IRQ_STATUS_OFF);
  assign wr_mask = do_write && lane0_r && (waddr_r == pwm_steer_pkg::IRQ_MASK_OFF);

  // Address and data are taken in either order, then written together
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_hold_r <= 1'b0;
      waddr_r <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_hold_r <= 1'b1;
      waddr_r <= AWADDR;
    end else if (do_write) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      lane0_r <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_hold_r <= 1'b1;
      wdata_r <= WDATA;
      lane0_r <= WSTRB[0];
    end else if (do_write) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bvalid_r <= 1'b0;
      bresp_r <= pwm_steer_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= addr_mapped(waddr_r) ? pwm_steer_pkg::RESP_OKAY : pwm_steer_pkg::RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= pwm_steer_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rresp_r <= addr_mapped(ARADDR) ? pwm_steer_pkg::RESP_OKAY : pwm_steer_pkg::RESP_SLVERR;
      case (ARADDR)
        pwm_steer_pkg::RESTART_DELAY_OFF: rdata_r <= {24'h000000, restart_delay_r};
        pwm_steer_pkg::STEER_CTRL_OFF: rdata_r <= {27'h0000000, steer_ctrl_r};
        pwm_steer_pkg::CCP_CTRL_OFF: rdata_r <= {24'h000000, ccp_r};
        pwm_steer_pkg::SHUTDOWN_STAT_OFF: rdata_r <= {29'h0000000, resume_wait_r, cond_r, flag_r};
        pwm_steer_pkg::IRQ_STATUS_OFF: rdata_r <= {30'h0000000, irq_status_r};
        pwm_steer_pkg::IRQ_MASK_OFF: rdata_r <= {30'h0000000, irq_mask_r};
        default: rdata_r <= '0;
      endcase
    end else if (RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      restart_delay_r <= pwm_steer_pkg::RESTART_DELAY_RST;
    end else if (wr_restart) begin
      restart_delay_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      steer_ctrl_r <= pwm_steer_pkg::STEER_CTRL_RST;
    end else if (wr_steer) begin
      steer_ctrl_r <= wdata_r[4:0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ccp_r <= pwm_steer_pkg::CCP_CTRL_RST;
    end else if (wr_ccp) begin
      ccp_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_mask_r <= '0;
    end else if (wr_mask) begin
      irq_mask_r <= wdata_r[pwm_steer_pkg::IRQ_W-1:0];
    end
  end

  // Shutdown condition comes from outside the clock domain
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cond_meta_r <= 1'b0;
      cond_r <= 1'b0;
    end else begin
      cond_meta_r <= SHUTDOWN_COND;
      cond_r <= cond_meta_r;
    end
  end

  assign auto_en = restart_delay_r[pwm_steer_pkg::AUTO_RESTART_BIT];

  always_comb begin
    flag_nxt = flag_r;
    if (auto_en && !cond_r) begin
      flag_nxt = 1'b0;
    end
    if (wr_sd) begin
      if (wdata_r[pwm_steer_pkg::SD_FLAG_BIT]) begin
        flag_nxt = 1'b1;
      end else if (!cond_r) begin
        flag_nxt = 1'b0;
      end
    end
    if (cond_r) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // After the flag drops, pins stay shut until the next period begins
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      resume_wait_r <= 1'b0;
    end else if (flag_r) begin
      resume_wait_r <= 1'b1;
    end else if (PERIOD_START) begin
      resume_wait_r <= 1'b0;
    end
  end

  assign shut = flag_r || resume_wait_r;

  // Sticky events, set wins over a write-one clear
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_irq_clr) begin
      irq_status_nxt = irq_status_r & ~wdata_r[pwm_steer_pkg::IRQ_W-1:0];
    end
    if (flag_nxt && !flag_r) begin
      irq_status_nxt[pwm_steer_pkg::IRQ_SHUTDOWN_BIT] = 1'b1;
    end
    if (resume_wait_r && !flag_r && PERIOD_START) begin
      irq_status_nxt[pwm_steer_pkg::IRQ_RESUME_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status_r <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      IRQ <= |(irq_status_nxt & irq_mask_r);
    end
  end

  assign dly_target = CW'(restart_delay_r[pwm_steer_pkg::DELAY_W-1:0] * pwm_steer_pkg::CLKS_PER_INSTR);

  pwm_rise_delay #(
    .CNT_W(CW)
  ) u_rise_delay (
    .clk(CLK),
    .rst(SYS_RST),
    .raw(RAW_PWM),
    .target(dly_target),
    .out_r(dly_pwm)
  );

  steer_update_sync #(
    .PINS(PINS)
  ) u_steer_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .wr(wr_steer),
    .wr_sel(wdata_r[PINS-1:0]),
    .wr_sync(wdata_r[pwm_steer_pkg::STEER_SYNC_BIT]),
    .period_start(PERIOD_START),
    .applied_r(steer_app)
  );

  assign mode_ok = (ccp_r[pwm_steer_pkg::MODE_HI:pwm_steer_pkg::MODE_LO] == pwm_steer_pkg::MODE_PWM)
    && (ccp_r[pwm_steer_pkg::CFG_HI:pwm_steer_pkg::CFG_LO] == pwm_steer_pkg::CFG_SINGLE);
  assign port_val = {PORT_OUT_D, PORT_OUT_C, PORT_OUT_B, PORT_OUT_A};
  assign pol_inv = {ccp_r[pwm_steer_pkg::POL_BD_BIT], ccp_r[pwm_steer_pkg::POL_AC_BIT],
    ccp_r[pwm_steer_pkg::POL_BD_BIT], ccp_r[pwm_steer_pkg::POL_AC_BIT]};

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (mode_ok && steer_app[i]) begin
        pin_nxt[i] = shut ? pwm_steer_pkg::SHUTDOWN_LEVEL : (dly_pwm ^ pol_inv[i]);
      end else begin
        pin_nxt[i] = port_val[i];
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign PWM_OUT_A = pin_r[0];
  assign PWM_OUT_B = pin_r[1];
  assign PWM_OUT_C = pin_r[2];
  assign PWM_OUT_D = pin_r[3];

  a_auto_clear:
  assert property (@(posedge CLK) disable iff (SYS_RST)
    auto_en && flag_r && !cond_r && !(wr_sd && wdata_r[pwm_steer_pkg::SD_FLAG_BIT]) |=> !flag_r)
    else $error("auto restart did not clear shutdown flag");

  a_manual_hold:
  assert property (@(posedge CLK) disable iff (SYS_RST)
    !auto_en && flag_r && !wr_sd |=> flag_r ##0 shut)
    else $error("shutdown flag dropped without software clear");

  a_flag_persists:
  assert property (@(posedge CLK) disable iff (SYS_RST) cond_r |=> flag_r)
    else $error("shutdown flag clear while condition active");

  a_clear_ignored:
  assert property (@(posedge CLK) disable iff (SYS_RST)
    cond_r && wr_sd && !wdata_r[pwm_steer_pkg::SD_FLAG_BIT] |=> flag_r)
    else $error("software clear accepted during shutdown condition");

  a_resume_period:
  assert property (@(posedge CLK) disable iff (SYS_RST)
    $fell(shut) |-> $past(PERIOD_START) && !$past(flag_r))
    else $error("output resumed outside a period start");

  a_port_pin:
  assert property (@(posedge CLK) disable iff (SYS_RST)
    !(mode_ok && steer_app[1]) |=> PWM_OUT_B == $past(PORT_OUT_B))
    else $error("unsteered pin does not carry port value");

  a_shut_steered:
  assert property (@(posedge CLK) disable iff (SYS_RST)
    mode_ok && steer_app[0] && shut |=> PWM_OUT_A == pwm_steer_pkg::SHUTDOWN_LEVEL)
    else $error("steered pin not forced during shutdown");

  a_polarity_out:
  assert property (@(posedge CLK) disable iff (SYS_RST)
    mode_ok && steer_app[3] && !shut |=>
    PWM_OUT_D == ($past(dly_pwm) ^ $past(ccp_r[pwm_steer_pkg::POL_BD_BIT])))
    else $error("steered pin polarity wrong");

endmodule

// >>> testbench/pin_load_model.sv
`timescale 1ns/100ps
// Switch driver load: counts rising edges seen on each pin
module pin_load_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] pin,
  output logic [15:0] rises_r
);
  logic [3:0] last_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_r <= 4'h0;
      rises_r <= 16'h0000;
    end else begin
      last_r <= pin;
      for (int i = 0; i < 4; i++) begin
        if (pin[i] && !last_r[i]) begin
          rises_r[4*i +: 4] <= rises_r[4*i +: 4] + 4'h1;
        end
      end
    end
  end
endmodule

// >>> testbench/test_pwm_steering_restart_delay.sv
`timescale 1ns/100ps
module test_pwm_steering_restart_delay;
  typedef struct packed {
    logic [7:0] ccp;
    logic [7:0] steer;
    logic raw;
    logic [3:0] port;
    logic [3:0] exp;
  } row_type;
  localparam row_type ROWS [8] = '{
    '{8'h0C, 8'h0F, 1'b1, 4'h0, 4'hF}, '{8'h0C, 8'h05, 1'b1, 4'h0, 4'h5},
    '{8'h0E, 8'h0F, 1'b1, 4'h0, 4'hA}, '{8'h0D, 8'h0F, 1'b1, 4'h0, 4'h5},
    '{8'h0F, 8'h0F, 1'b0, 4'h0, 4'hF}, '{8'h4C, 8'h0F, 1'b1, 4'h6, 4'h6},
    '{8'h08, 8'h0F, 1'b1, 4'h9, 4'h9}, '{8'h0C, 8'h00, 1'b1, 4'hC, 4'hC}};
  logic CLK, SYS_RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, IRQ;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0] WSTRB, port_v, pins;
  logic [1:0] BRESP, RRESP, r;
  logic SHUTDOWN_COND, PERIOD_START, RAW_PWM, PWM_OUT_A, PWM_OUT_B, PWM_OUT_C, PWM_OUT_D;
  logic [15:0] rises;
  logic [3:0] rb;
  int fail_count = 0;
  int n_compared = 0;
  int n;
  assign pins = {PWM_OUT_D, PWM_OUT_C, PWM_OUT_B, PWM_OUT_A};
  pwm_steering_restart_delay i_pwm_steering_restart_delay (.CLK(CLK), .SYS_RST(SYS_RST),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .SHUTDOWN_COND(SHUTDOWN_COND), .PERIOD_START(PERIOD_START),
    .RAW_PWM(RAW_PWM), .PORT_OUT_A(port_v[0]), .PORT_OUT_B(port_v[1]), .PORT_OUT_C(port_v[2]),
    .PORT_OUT_D(port_v[3]), .PWM_OUT_A(PWM_OUT_A), .PWM_OUT_B(PWM_OUT_B),
    .PWM_OUT_C(PWM_OUT_C), .PWM_OUT_D(PWM_OUT_D), .IRQ(IRQ));
  pin_load_model i_pin_load_model (.clk(CLK), .rst(SYS_RST), .pin(pins), .rises_r(rises));
  always #2 CLK = ~CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic clk_n(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task automatic chk_pins(input logic [3:0] exp);
    @(negedge CLK);
    chk({28'h0, pins}, {28'h0, exp});
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, aw_done, w_done, b;
    aw_done = 1'b0;
    w_done = 1'b0;
    b = 1'b0;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge CLK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      @(posedge CLK);
      if (ta) begin
        AWVALID <= 1'b0;
        aw_done = 1'b1;
      end
      if (tw) begin
        WVALID <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!b) begin
      @(negedge CLK);
      b = BVALID;
      r = BRESP;
      @(posedge CLK);
    end
    BREADY <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    logic ta, b;
    ta = 1'b0;
    b = 1'b0;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!ta) begin
      @(negedge CLK);
      ta = ARREADY;
      @(posedge CLK);
    end
    ARVALID <= 1'b0;
    while (!b) begin
      @(negedge CLK);
      b = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
    end
    RREADY <= 1'b0;
  endtask
  task automatic pulse_period;
    @(posedge CLK);
    PERIOD_START <= 1'b1;
    @(posedge CLK);
    PERIOD_START <= 1'b0;
  endtask
  task final_report;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    CLK = 0;
    SYS_RST = 1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hF;
    {SHUTDOWN_COND, PERIOD_START, RAW_PWM, port_v} = 7'h00;
    clk_n(8);
    SYS_RST <= 1'b0;
    axi_read(8'h00);
    chk(d, 32'h0000_0000);
    axi_read(8'h04);
    chk(d, 32'h0000_0001);
    axi_read(8'h08);
    chk(d, 32'h0000_0000);
    axi_read(8'h14);
    chk(d, 32'h0000_0000);
    axi_read(8'h1C);
    chk({30'h0, r}, 32'h0000_0002);
    axi_write(8'h1C, 32'h0000_00FF);
    chk({30'h0, r}, 32'h0000_0002);
    axi_write(8'h04, 32'h0000_00FF);
    axi_read(8'h04);
    chk(d, 32'h0000_001F);
    WSTRB <= 4'h0;
    axi_write(8'h00, 32'h0000_007F);
    chk({30'h0, r}, 32'h0000_0000);
    WSTRB <= 4'hF;
    axi_read(8'h00);
    chk(d, 32'h0000_0000);
    $display("registers done");
    foreach (ROWS[i]) begin
      axi_write(8'h08, {24'h0, ROWS[i].ccp});
      axi_write(8'h04, {24'h0, ROWS[i].steer});
      @(posedge CLK);
      RAW_PWM <= ROWS[i].raw;
      port_v <= ROWS[i].port;
      clk_n(4);
      chk_pins(ROWS[i].exp);
    end
    $display("table done");
    axi_write(8'h08, 32'h0000_000C);
    axi_write(8'h04, 32'h0000_0001);
    @(posedge CLK);
    RAW_PWM <= 1'b0;
    port_v <= 4'h0;
    axi_write(8'h00, 32'h0000_0003);
    clk_n(3);
    RAW_PWM <= 1'b1;
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (pins[0] !== 1'b1 && n < 100);
    chk({31'h0, n >= 12 && n <= 16}, 32'h1);
    @(posedge CLK);
    RAW_PWM <= 1'b0;
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (pins[0] !== 1'b0 && n < 100);
    chk({31'h0, n <= 3}, 32'h1);
    axi_write(8'h00, 32'h0000_0000);
    $display("delay done");
    @(posedge CLK);
    RAW_PWM <= 1'b1;
    axi_write(8'h04, 32'h0000_0012);
    chk_pins(4'h1);
    rb = rises[7:4];
    pulse_period();
    clk_n(2);
    chk_pins(4'h2);
    chk({28'h0, 4'(rises[7:4] - rb)}, 32'h1);
    axi_write(8'h04, 32'h0000_0004);
    clk_n(1);
    chk_pins(4'h4);
    $display("sync done");
    axi_write(8'h04, 32'h0000_0003);
    axi_write(8'h14, 32'h0000_0003);
    axi_write(8'h00, 32'h0000_0080);
    port_v <= 4'hF;
    SHUTDOWN_COND <= 1'b1;
    clk_n(8);
    chk_pins(4'hC);
    chk({31'h0, IRQ}, 32'h1);
    axi_write(8'h0C, 32'h0000_0000);
    axi_read(8'h0C);
    chk(d & 32'h3, 32'h3);
    SHUTDOWN_COND <= 1'b0;
    clk_n(6);
    axi_read(8'h0C);
    chk(d & 32'h1, 32'h0);
    chk_pins(4'hC);
    pulse_period();
    clk_n(2);
    chk_pins(4'hF);
    axi_write(8'h10, 32'h0000_0003);
    clk_n(2);
    chk({31'h0, IRQ}, 32'h0);
    $display("auto restart done");
    axi_write(8'h14, 32'h0000_0000);
    axi_write(8'h00, 32'h0000_0000);
    SHUTDOWN_COND <= 1'b1;
    clk_n(8);
    SHUTDOWN_COND <= 1'b0;
    clk_n(6);
    axi_read(8'h0C);
    chk(d & 32'h1, 32'h1);
    chk({31'h0, IRQ}, 32'h0);
    pulse_period();
    clk_n(2);
    chk_pins(4'hC);
    axi_write(8'h14, 32'h0000_0001);
    clk_n(2);
    chk({31'h0, IRQ}, 32'h1);
    axi_write(8'h0C, 32'h0000_0000);
    pulse_period();
    clk_n(2);
    chk_pins(4'hF);
    axi_write(8'h10, 32'h0000_0003);
    clk_n(2);
    chk({31'h0, IRQ}, 32'h0);
    $display("firmware restart done");
    final_report();
  end
endmodule
